// >>> bench/prurin_checker.sv
// Port-level checks on the user-record insertion core
`timescale 1ns/1ps
module prurin_checker (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire ins_valid,
    input wire ins_ready,
    input wire [63:0] ins_ip,
    input wire protected_mode,
    input wire feature_present,
    input wire profiler_enable,
    input wire [63:0] cb_addr,
    input wire ins_done,
    input wire carry_flag,
    input wire undefined_opcode_fault,
    input wire cb_fault,
    input wire retired_pulse,
    input wire [63:0] retired_ip,
    input wire mem_rd_req,
    input wire [63:0] mem_rd_addr,
    input wire mem_rd_err,
    input wire session_loaded,
    input wire [31:0] producer_offset,
    input wire [63:0] lost_record_count
);
    default clocking dclk @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    reg [63:0] take_ip;
    wire take = ins_valid && ins_ready && clk_en && (session_loaded || !profiler_enable);
    wire legal = protected_mode && feature_present;
    // Keep the taken address, the retire report must name that instruction
    always @(posedge sys_clk)
    begin
        if (take)
            take_ip <= ins_ip;
    end
    sequence s_bad;
        take && !legal;
    endsequence
    sequence s_live;
        take && legal && profiler_enable;
    endsequence
    sequence s_cons;
        mem_rd_req && mem_rd_addr == cb_addr + 64'h40;
    endsequence
    a_bad_fault: assert property (s_bad |-> ##1 undefined_opcode_fault)
        else $error("opcode fault missing");
    a_off_nop: assert property (take && legal && !profiler_enable |->
        ##2 (ins_done && !carry_flag))
        else $error("disabled insert not a no-op");
    a_cons_read: assert property (s_live |-> ##[1:2] s_cons)
        else $error("consumer read address wrong");
    a_load_map: assert property (mem_rd_req && !session_loaded |->
        (mem_rd_addr - cb_addr) inside {64'h0, 64'h8, 64'h10, 64'h18, 64'h20})
        else $error("load read off the block map");
    a_lost_step: assert property ($changed(lost_record_count) && $past(session_loaded) |->
        lost_record_count == $past(lost_record_count) + 64'h1)
        else $error("lost count jumped");
    a_prod_step: assert property ($changed(producer_offset) && $past(session_loaded) |->
        producer_offset == $past(producer_offset) + 32'h20 || producer_offset == 32'h0)
        else $error("producer step wrong");
    a_full_hold: assert property ($rose(carry_flag) |-> $stable(producer_offset) &&
        lost_record_count == $past(lost_record_count) + 64'h1)
        else $error("full insert moved producer");
    a_retire_ip: assert property (retired_pulse |-> ins_done && retired_ip == take_ip)
        else $error("retire report wrong");
    a_rd_fault: assert property (mem_rd_req && mem_rd_err |-> ##[1:3] cb_fault)
        else $error("block read error not reported");
endmodule // prurin_checker
bind prurin_core prurin_checker prurin_checker_inst (.*);

// >>> bench/prurin_core_tb.sv
// Self-checking bench for the insertion core
`timescale 1ns/1ps
module prurin_core_tb;
    reg sys_clk;
    reg sys_rst;
    reg ins_valid;
    reg ins_op1_is32;
    reg protected_mode;
    reg feature_present;
    reg profiler_enable;
    reg continuous_mode;
    reg fail_rd;
    reg got_irq;
    reg got_ud;
    reg got_cbf;
    reg held;
    reg flush_req;
    reg [3:0] lag;
    reg [31:0] ins_op2, ins_imm, p, cons, adv;
    reg [63:0] ins_op1, ins_ip, ret_ip, w, lost;
    integer err_total, num_checks, i;
    wire clk_en = 1'b1;
    wire [63:0] cb_addr = 64'h0;
    wire ins_ready, ins_done, carry_flag, undefined_opcode_fault, cb_fault, threshold_irq;
    wire retired_pulse, mem_rd_req, mem_rd_ack, mem_rd_err, mem_wr_req, mem_wr_ack, mem_wr_err;
    wire session_loaded;
    wire [31:0] producer_offset;
    wire [63:0] retired_ip, mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data, lost_record_count;
    prurin_core prurin_core_inst (.*);
    prurin_mem_model prurin_mem_model_inst (.*);
    initial
    begin
        sys_clk = 1'b0;
        forever
            #25 sys_clk = ~sys_clk;
    end
    task chk(input [63:0] got, input [63:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // Issue insert n, then gather pulses until done and the write port is quiet
    task ins(input integer n);
        integer t;
        integer q;
    begin
        ins_op1 = 64'hFEDCBA9876543210;
        ins_op1_is32 = n[0];
        ins_op2 = 32'h11111111 * (n + 1);
        ins_imm = 32'hBEEF0100 + n;
        ins_ip = 64'h8000 + n * 4;
        ins_valid = 1'b1;
        {got_irq, got_ud, got_cbf} = 3'h0;
        ret_ip = 64'h0;
        t = 0;
        q = -1;
        while (!ins_ready)
            @(posedge sys_clk) #1;
        @(posedge sys_clk) #1;
        ins_valid = 1'b0;
        while (q < 4 && t < 300)
        begin
            got_irq = got_irq | threshold_irq;
            got_ud = got_ud | undefined_opcode_fault;
            got_cbf = got_cbf | cb_fault;
            if (retired_pulse)
                ret_ip = retired_ip;
            if (ins_done || undefined_opcode_fault || cb_fault)
                q = 0;
            else if (q >= 0)
                q = mem_wr_req ? 0 : q + 1;
            t = t + 1;
            @(posedge sys_clk) #1;
        end
    end
    endtask
    initial
    begin
        {err_total, num_checks, p, lost} = 0;
        {sys_rst, feature_present} = 2'h3;
        {ins_valid, protected_mode, profiler_enable, continuous_mode, fail_rd, flush_req} = 6'h0;
        {ins_op1, ins_op1_is32, ins_op2, ins_imm, ins_ip, lag} = 0;
        repeat (8) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        // Block set up before enabling: size 0x80, threshold irq on, base 0x200, level 0x40
        prurin_mem_model_inst.mem[0] = 64'h0000008080000000;
        prurin_mem_model_inst.mem[1] = 64'h200;
        prurin_mem_model_inst.mem[4] = 64'h40;
        ins(9);
        chk(got_ud, 1);
        {protected_mode, feature_present} = 2'h2;
        ins(9);
        chk(got_ud, 1);
        {feature_present, profiler_enable} = 2'h3;
        for (i = 0; i < 300 && !session_loaded; i = i + 1)
            @(posedge sys_clk) #1;
        chk(session_loaded, 1);
        // Three plain, one continuous wrap, one synchronized full; memory slows each time
        for (i = 0; i < 5; i = i + 1)
        begin
            lag = i * 2;
            continuous_mode = (i == 3);
            cons = (i == 4) ? 32'h20 : 32'h0;
            prurin_mem_model_inst.mem[8] = cons;
            adv = (p + 32'h20) % 32'h80;
            held = (adv == cons) && !continuous_mode;
            ins(i);
            w = prurin_mem_model_inst.mem[64 + p / 8];
            chk(w[7:0], 8'hFF);
            chk(w[31:16], 16'h0100 + i);
            chk(w[63:32], 32'h11111111 * (i + 1));
            w = prurin_mem_model_inst.mem[66 + p / 8];
            chk(w, i[0] ? 64'h76543210 : 64'hFEDCBA9876543210);
            if (adv == cons)
                lost = lost + 1;
            if (!held)
                p = adv;
            chk(producer_offset, p);
            chk(lost_record_count, lost);
            chk(carry_flag, held);
            chk(got_irq, !held && ((p - cons) % 32'h80 >= 32'h40));
            chk(ret_ip, 64'h8000 + i * 4);
        end
        // Flush writes the progress fields back into the block
        flush_req = 1'b1;
        @(posedge sys_clk) #1;
        flush_req = 1'b0;
        for (i = 0; i < 300 && !ins_ready; i = i + 1)
            @(posedge sys_clk) #1;
        chk(prurin_mem_model_inst.mem[2], {32'h0, p});
        chk(prurin_mem_model_inst.mem[3], lost);
        fail_rd = 1'b1;
        ins(5);
        chk(got_cbf, 1);
        fail_rd = 1'b0;
        // Profiling off: only the carry left by the full buffer goes
        profiler_enable = 1'b0;
        ins(6);
        chk(carry_flag, 0);
        chk(got_ud, 0);
        wrap_up;
    end
    // Tests need a few hundred cycles; this bound only cuts a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total = err_total + 1;
        wrap_up;
    end
endmodule // prurin_core_tb

// >>> bench/prurin_mem_model.sv
// Memory holding the control block at 0 and the ring buffer at 0x200
`timescale 1ns/1ps
module prurin_mem_model (
    input wire sys_clk,
    input wire [3:0] lag,
    input wire fail_rd,
    input wire mem_rd_req,
    input wire [63:0] mem_rd_addr,
    output reg [63:0] mem_rd_data,
    output reg mem_rd_ack,
    output reg mem_rd_err,
    input wire mem_wr_req,
    input wire [63:0] mem_wr_addr,
    input wire [63:0] mem_wr_data,
    output reg mem_wr_ack,
    output reg mem_wr_err
);
    reg [63:0] mem [0:127];
    reg [3:0] wait_cnt;
    integer i;
    // Reserved fields start at zero
    initial
    begin
        for (i = 0; i < 128; i = i + 1)
            mem[i] = 64'h0;
        mem_rd_data = 64'h0;
        mem_rd_ack = 1'b0;
        mem_rd_err = 1'b0;
        mem_wr_ack = 1'b0;
        mem_wr_err = 1'b0;
        wait_cnt = 4'h0;
    end
    // One answer per request after lag cycles; reads win; idle data keeps toggling
    always @(posedge sys_clk)
    begin
        mem_rd_ack <= 1'b0;
        mem_rd_err <= 1'b0;
        mem_wr_ack <= 1'b0;
        mem_rd_data <= ~mem_rd_data;
        if ((mem_rd_req || mem_wr_req) && !mem_rd_ack && !mem_rd_err && !mem_wr_ack)
        begin
            if (wait_cnt < lag)
                wait_cnt <= wait_cnt + 4'h1;
            else if (mem_rd_req)
            begin
                wait_cnt <= 4'h0;
                mem_rd_err <= fail_rd;
                mem_rd_ack <= !fail_rd;
                mem_rd_data <= mem[mem_rd_addr[9:3]];
            end
            else
            begin
                wait_cnt <= 4'h0;
                mem_wr_ack <= 1'b1;
                mem[mem_wr_addr[9:3]] <= mem_wr_data;
            end
        end
    end
endmodule // prurin_mem_model

// >>> core/prurin_core.v
// Profiler user-record insertion engine with control block access
`timescale 1ns/1ps
`include "prurin_regs.vh"
module prurin_core #(
    parameter DEPTH = 32
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire ins_valid,
    output wire ins_ready,
    input wire [63:0] ins_op1,
    input wire ins_op1_is32,
    input wire [31:0] ins_op2,
    input wire [31:0] ins_imm,
    input wire [63:0] ins_ip,
    input wire protected_mode,
    input wire feature_present,
    input wire profiler_enable,
    input wire [63:0] cb_addr,
    input wire continuous_mode,
    input wire flush_req,
    output reg ins_done,
    output reg carry_flag,
    output reg undefined_opcode_fault,
    output reg cb_fault,
    output reg threshold_irq,
    output reg retired_pulse,
    output reg [63:0] retired_ip,
    output reg mem_rd_req,
    output reg [63:0] mem_rd_addr,
    input wire [63:0] mem_rd_data,
    input wire mem_rd_ack,
    input wire mem_rd_err,
    output wire mem_wr_req,
    output wire [63:0] mem_wr_addr,
    output wire [63:0] mem_wr_data,
    input wire mem_wr_ack,
    input wire mem_wr_err,
    output reg session_loaded,
    output reg [31:0] producer_offset,
    output reg [63:0] lost_record_count
);
    localparam ST_IDLE = 4'h0;
    localparam ST_LD_SIZE = 4'h1;
    localparam ST_LD_BASE = 4'h2;
    localparam ST_LD_PROD = 4'h3;
    localparam ST_LD_LOST = 4'h4;
    localparam ST_LD_THR = 4'h5;
    localparam ST_RD_CONS = 4'h6;
    localparam ST_REC = 4'h7;
    localparam ST_FL_PROD = 4'h8;
    localparam ST_FL_LOST = 4'h9;
    localparam ST_DRAIN = 4'hA;
    localparam ST_DONE = 4'hB;

    reg [3:0] state;
    reg [1:0] word_idx;
    reg [31:0] flags_sh;
    reg [31:0] size_sh;
    reg [63:0] base_sh;
    reg [31:0] thresh_sh;
    reg [31:0] cons_sh;
    reg [63:0] rec_op1;
    reg [31:0] rec_op2;
    reg [15:0] rec_imm;
    reg [63:0] rec_ip;
    reg rec_full;
    reg flush_pend;
    reg fifo_in_valid;
    reg [127:0] fifo_in_data;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [127:0] fifo_out_data;
    wire wr_fault;
    wire [31:0] size_eff;
    wire [31:0] prod_sane;
    wire [31:0] prod_next;
    wire [31:0] used_space;
    wire [63:0] rec_addr;
    wire rd_done;

    // Size and producer offset rounded down to whole records; consumer offset used as read
    assign size_eff = size_sh & `PRURIN_SIZE_MASK & ~(`PRURIN_REC_BYTES - 32'h00000001);
    assign prod_sane = (producer_offset >= size_eff) ? 32'h00000000 :
        (producer_offset & ~(`PRURIN_REC_BYTES - 32'h00000001));
    assign prod_next = (prod_sane + `PRURIN_REC_BYTES >= size_eff) ? 32'h00000000 :
        prod_sane + `PRURIN_REC_BYTES;
    // Used space after advance, modulo buffer size
    assign used_space = (prod_next >= cons_sh) ? prod_next - cons_sh :
        prod_next + size_eff - cons_sh;
    assign rec_addr = base_sh + {32'h00000000, prod_sane};
    assign rd_done = mem_rd_req && (mem_rd_ack || mem_rd_err);
    assign ins_ready = (state == ST_IDLE) && !flush_pend;

    prurin_fifo #(
        .WIDTH(128),
        .DEPTH(DEPTH),
        .AW(5)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    prurin_memwr #(
        .AW(64),
        .DW(64)
    ) u_memwr (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(fifo_out_valid),
        .in_ready(fifo_out_ready),
        .in_data(fifo_out_data),
        .mem_wr_req(mem_wr_req),
        .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data),
        .mem_wr_ack(mem_wr_ack),
        .mem_wr_err(mem_wr_err),
        .wr_fault(wr_fault)
    );

    // Record word builder: four 64-bit words per 32-byte record
    always @*
    begin
        fifo_in_data = 128'h0;
        case (word_idx)
            2'h0: fifo_in_data[63:0] = {rec_op2, rec_imm, 8'h00, `PRURIN_TYPE_USER};
            2'h1: fifo_in_data[63:0] = rec_ip;
            2'h2: fifo_in_data[63:0] = rec_op1;
            default: fifo_in_data[63:0] = 64'h0;
        endcase
        fifo_in_data[127:64] = rec_addr + {59'h0, word_idx, 3'h0};
        // Flush words carry the device-owned progress fields to their home slots
        if (state == ST_FL_PROD)
        begin
            fifo_in_data[63:0] = {32'h00000000, producer_offset};
            fifo_in_data[127:64] = cb_addr + {56'h0, `PRURIN_OFF_PROD};
        end
        else if (state == ST_FL_LOST)
        begin
            fifo_in_data[63:0] = lost_record_count;
            fifo_in_data[127:64] = cb_addr + {56'h0, `PRURIN_OFF_LOST};
        end
    end

    // Main sequencer: session load, record insertion and flush
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            word_idx <= 2'h0;
            flags_sh <= 32'h0;
            size_sh <= 32'h0;
            base_sh <= 64'h0;
            thresh_sh <= 32'h0;
            cons_sh <= 32'h0;
            rec_op1 <= 64'h0;
            rec_op2 <= 32'h0;
            rec_imm <= 16'h0;
            rec_ip <= 64'h0;
            rec_full <= 1'b0;
            flush_pend <= 1'b0;
            fifo_in_valid <= 1'b0;
            ins_done <= 1'b0;
            carry_flag <= 1'b0;
            undefined_opcode_fault <= 1'b0;
            cb_fault <= 1'b0;
            threshold_irq <= 1'b0;
            retired_pulse <= 1'b0;
            retired_ip <= 64'h0;
            mem_rd_req <= 1'b0;
            mem_rd_addr <= 64'h0;
            session_loaded <= 1'b0;
            producer_offset <= 32'h0;
            lost_record_count <= 64'h0;
        end
        else if (clk_en)
        begin
            ins_done <= 1'b0;
            undefined_opcode_fault <= 1'b0;
            threshold_irq <= 1'b0;
            retired_pulse <= 1'b0;
            cb_fault <= wr_fault;
            if (flush_req)
                flush_pend <= 1'b1;
            if (rd_done)
                mem_rd_req <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    // Disabling ends the session but must not block a pending insert
                    if (!profiler_enable)
                        session_loaded <= 1'b0;
                    if (profiler_enable && !session_loaded)
                    begin
                        // Flags, size, base, threshold and the producer and lost progress fields loaded once per session
                        mem_rd_req <= 1'b1;
                        mem_rd_addr <= cb_addr + {56'h0, `PRURIN_OFF_FLAGS};
                        state <= ST_LD_SIZE;
                    end
                    else if (flush_pend)
                    begin
                        flush_pend <= 1'b0;
                        state <= ST_FL_PROD;
                    end
                    else if (ins_valid)
                    begin
                        rec_op1 <= ins_op1_is32 ? {32'h00000000, ins_op1[31:0]} : ins_op1;
                        rec_op2 <= ins_op2;
                        rec_imm <= ins_imm[15:0];
                        rec_ip <= ins_ip;
                        if (!protected_mode || !feature_present)
                        begin
                            undefined_opcode_fault <= 1'b1;
                            ins_done <= 1'b1;
                        end
                        else
                        begin
                            // Consumer offset re-read for every insert; no read when disabled
                            mem_rd_req <= profiler_enable;
                            mem_rd_addr <= cb_addr + {56'h0, `PRURIN_OFF_CONS};
                            state <= ST_RD_CONS;
                        end
                    end
                end
                ST_LD_SIZE, ST_LD_BASE, ST_LD_PROD, ST_LD_LOST, ST_LD_THR:
                begin
                    if (rd_done && mem_rd_err)
                    begin
                        cb_fault <= 1'b1;
                        state <= ST_IDLE;
                    end
                    else if (rd_done)
                    begin
                        mem_rd_req <= (state != ST_LD_THR);
                        state <= (state == ST_LD_THR) ? ST_IDLE : state + 4'h1;
                        case (state)
                            ST_LD_SIZE:
                            begin
                                flags_sh <= mem_rd_data[31:0];
                                size_sh <= mem_rd_data[63:32];
                                mem_rd_addr <= cb_addr + {56'h0, `PRURIN_OFF_BASE};
                            end
                            ST_LD_BASE:
                            begin
                                base_sh <= mem_rd_data;
                                mem_rd_addr <= cb_addr + {56'h0, `PRURIN_OFF_PROD};
                            end
                            ST_LD_PROD:
                            begin
                                producer_offset <= mem_rd_data[31:0];
                                mem_rd_addr <= cb_addr + {56'h0, `PRURIN_OFF_LOST};
                            end
                            ST_LD_LOST:
                            begin
                                lost_record_count <= mem_rd_data;
                                mem_rd_addr <= cb_addr + {56'h0, `PRURIN_OFF_THRESH};
                            end
                            default:
                            begin
                                thresh_sh <= mem_rd_data[31:0];
                                session_loaded <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_RD_CONS:
                begin
                    if (!session_loaded)
                    begin
                        // Disabled profiler just clears carry
                        mem_rd_req <= 1'b0;
                        carry_flag <= 1'b0;
                        ins_done <= 1'b1;
                        state <= ST_IDLE;
                    end
                    else if (rd_done && mem_rd_err)
                    begin
                        cb_fault <= 1'b1;
                        ins_done <= 1'b1;
                        state <= ST_IDLE;
                    end
                    else if (rd_done)
                    begin
                        cons_sh <= mem_rd_data[31:0];
                        rec_full <= (prod_next == mem_rd_data[31:0]);
                        word_idx <= 2'h0;
                        fifo_in_valid <= 1'b1;
                        state <= ST_REC;
                    end
                end
                ST_REC:
                begin
                    // Back-pressure from the FIFO stalls the record writer
                    if (fifo_in_valid && fifo_in_ready)
                    begin
                        word_idx <= word_idx + 2'h1;
                        if (word_idx == 2'h3)
                        begin
                            fifo_in_valid <= 1'b0;
                            if (!rec_full || continuous_mode)
                            begin
                                producer_offset <= prod_next;
                                carry_flag <= 1'b0;
                                if (rec_full)
                                    lost_record_count <= lost_record_count + 64'h1;
                                if (flags_sh[`PRURIN_FLAG_THRINT] && used_space >= thresh_sh)
                                    threshold_irq <= 1'b1;
                            end
                            else
                            begin
                                producer_offset <= prod_sane;
                                lost_record_count <= lost_record_count + 64'h1;
                                carry_flag <= 1'b1;
                            end
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE:
                begin
                    ins_done <= 1'b1;
                    retired_pulse <= 1'b1;
                    retired_ip <= rec_ip;
                    state <= ST_IDLE;
                end
                ST_FL_PROD:
                begin
                    // Progress fields written back through the same FIFO
                    if (!fifo_in_valid)
                        fifo_in_valid <= 1'b1;
                    else if (fifo_in_ready)
                        fifo_in_valid <= 1'b0;
                    if (fifo_in_valid && fifo_in_ready)
                        state <= ST_FL_LOST;
                end
                ST_FL_LOST:
                begin
                    if (!fifo_in_valid)
                        fifo_in_valid <= 1'b1;
                    else if (fifo_in_ready)
                        fifo_in_valid <= 1'b0;
                    if (fifo_in_valid && fifo_in_ready)
                        state <= ST_DRAIN;
                end
                ST_DRAIN:
                begin
                    if (!fifo_out_valid && !mem_wr_req)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule // prurin_core

// >>> core/prurin_fifo.v
// Record word FIFO towards the memory writer
`timescale 1ns/1ps
module prurin_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // Honest full and empty from the fill count
    assign in_ready = (count != DEPTH);
    assign out_valid = (count != 0);
    assign out_data = mem[rd_ptr];
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;

    // Storage has no reset, pointers do
    always @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointer and count update
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // prurin_fifo

// >>> core/prurin_memwr.v
// Memory write port that drains record words from the FIFO
`timescale 1ns/1ps
module prurin_memwr #(
    parameter AW = 64,
    parameter DW = 64
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire in_valid,
    output wire in_ready,
    input wire [AW+DW-1:0] in_data,
    output reg mem_wr_req,
    output reg [AW-1:0] mem_wr_addr,
    output reg [DW-1:0] mem_wr_data,
    input wire mem_wr_ack,
    input wire mem_wr_err,
    output reg wr_fault
);
    // Accept a new word only when no write is outstanding
    assign in_ready = !mem_wr_req;

    // One outstanding write; an error is a one-cycle fault pulse
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            mem_wr_req <= 1'b0;
            mem_wr_addr <= {AW{1'b0}};
            mem_wr_data <= {DW{1'b0}};
            wr_fault <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_fault <= 1'b0;
            if (mem_wr_req && (mem_wr_ack || mem_wr_err))
            begin
                mem_wr_req <= 1'b0;
                wr_fault <= mem_wr_err;
            end
            else if (!mem_wr_req && in_valid)
            begin
                mem_wr_req <= 1'b1;
                mem_wr_addr <= in_data[AW+DW-1:DW];
                mem_wr_data <= in_data[DW-1:0];
            end
        end
    end
endmodule // prurin_memwr

// >>> core/prurin_regs.vh
// Constants for the profiler user-record insertion block
`ifndef PRURIN_REGS_VH
`define PRURIN_REGS_VH
`define PRURIN_TYPE_USER 8'hFF
`define PRURIN_OFF_FLAGS 8'h00
`define PRURIN_OFF_SIZE 8'h04
`define PRURIN_OFF_BASE 8'h08
`define PRURIN_OFF_PROD 8'h10
`define PRURIN_OFF_LOST 8'h18
`define PRURIN_OFF_THRESH 8'h20
`define PRURIN_OFF_IPLO 8'h28
`define PRURIN_OFF_IPHI 8'h30
`define PRURIN_OFF_CONS 8'h40
`define PRURIN_OFF_PERIOD1 8'h80
`define PRURIN_REC_BYTES 32'h00000020
`define PRURIN_FLAG_THRINT 31
`define PRURIN_SIZE_MASK 32'h0FFFFFFF
`endif
